// file: src/cbs_shifter.sv
/*
 * conditional barrel shifter: decodes shift instructions, picks
 * an operand, shifts by the shift code and updates the result.
 * assumes: one processor clock, inputs synchronous to it, the
 * instruction source pairs double precision halves itself.
 */
// The address map and the strobed register port were chosen for this implementation.
`include "cbs_regs.svh"
`default_nettype none

// How it works
// - false condition is no-op, none means always
// - code sign picks direction, positive goes left except for normalize
// - distance is the code magnitude
// - high or low half reference of field
// - or option merges, pass option overwrites
// - arithmetic copies sign left, zeros right
// - arithmetic drops bits beyond the field
// - logical left fills zeros, drops above 31
// - logical right fills zeros, drops below 0
// - normalize shifts arithmetically, zeros from right
// - normalize low fills zeros left, drops top
// - normalize high overflow code fills from carry
// - shifts never change arithmetic status flags
// - decode type sixteen format, zero bits checked
// - codes four to seven are arithmetic
// - codes zero to three are logical
// - codes eight to eleven are normalize
// - overflow exponent mode stores plus one when the overflow flag is set
module cbs_shifter (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    input wire logic I_INSTR_VALID,
    input wire logic [23:0] I_INSTR,
    input wire cbs_pkg::cbs_word_type I_SHIFTER_IN,
    input wire cbs_pkg::cbs_word_type I_ALU_RESULT,
    input wire cbs_pkg::cbs_word_type I_MAC_RESULT_TOP,
    input wire cbs_pkg::cbs_word_type I_MAC_RESULT_MID,
    input wire cbs_pkg::cbs_word_type I_MAC_RESULT_LOW,
    input wire logic [7:0] I_ARITH_STATUS,
    input wire logic I_COUNTER_EXPIRED,
    input wire logic I_EXP_WE,
    input wire logic I_EXP_HIX,
    input wire cbs_pkg::cbs_code_type I_EXP_CODE,
    input wire logic [`CBS_ADDR_W-1:0] I_ADDR,
    input wire cbs_pkg::cbs_word_type I_WR_DATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output cbs_pkg::cbs_word_type O_RD_DATA,
    output cbs_pkg::cbs_word_type O_SHIFT_RESULT_UPPER,
    output cbs_pkg::cbs_word_type O_SHIFT_RESULT_LOWER,
    output cbs_pkg::cbs_code_type O_SHIFT_CODE,
    output logic O_CODE_FROM_HIX,
    output logic O_EXEC_DONE
);
    import cbs_pkg::*;

    ////////////////////////////////////////////////////////////////
    // declarations
    cbs_state_type st; // registered state
    cbs_state_type next_st; // its next value
    logic [3:0] sf; // function field
    logic [2:0] xop; // operand select
    logic [3:0] cond; // condition field
    logic legal; // well formed shift instruction
    logic cond_ok; // condition holds
    logic exec_go; // shift is carried out this cycle
    cbs_op_type op_kind; // decoded shift kind
    logic ref_lo; // low half reference
    logic use_or; // merge into result
    cbs_word_type op_value; // selected operand
    logic [31:0] field; // operand placed in the 32 bit field
    cbs_code_type amount; // signed distance handed to the core
    logic fill; // bit entering from the top
    logic [31:0] shifted; // core output
    logic [31:0] merged; // value written to the result
    logic hix_store; // exponent store forced to plus one

    ////////////////////////////////////////////////////////////////
    // condition evaluation on the status word
    function automatic logic cond_true(
        input logic [3:0] c,
        input logic [7:0] s,
        input logic ce
    );
        logic lt;
        lt = s[`CBS_STAT_NEG] ^ s[`CBS_STAT_OVF];
        case (c)
            `CBS_COND_EQ: cond_true = s[`CBS_STAT_ZERO];
            `CBS_COND_NE: cond_true = !s[`CBS_STAT_ZERO];
            `CBS_COND_GT: cond_true = !(lt | s[`CBS_STAT_ZERO]);
            `CBS_COND_LE: cond_true = lt | s[`CBS_STAT_ZERO];
            `CBS_COND_LT: cond_true = lt;
            `CBS_COND_GE: cond_true = !lt;
            `CBS_COND_AV: cond_true = s[`CBS_STAT_OVF];
            `CBS_COND_NOT_AV: cond_true = !s[`CBS_STAT_OVF];
            `CBS_COND_AC: cond_true = s[`CBS_STAT_CARRY];
            `CBS_COND_NOT_AC: cond_true = !s[`CBS_STAT_CARRY];
            `CBS_COND_NEG: cond_true = s[`CBS_STAT_NEG];
            `CBS_COND_POS: cond_true = !s[`CBS_STAT_NEG];
            `CBS_COND_MV: cond_true = s[`CBS_STAT_MAC_OVF];
            `CBS_COND_NOT_MV: cond_true = !s[`CBS_STAT_MAC_OVF];
            `CBS_COND_NOT_CE: cond_true = !ce;
            default: cond_true = 1'b1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////
    // decode, operand select, field build
    always_comb
    begin
        sf = I_INSTR[`CBS_SF_MSB:`CBS_SF_LSB];
        xop = I_INSTR[`CBS_XOP_MSB:`CBS_XOP_LSB];
        cond = I_INSTR[`CBS_COND_MSB:`CBS_COND_LSB];
        ref_lo = sf[`CBS_SF_LO_BIT];
        use_or = sf[`CBS_SF_OR_BIT];
        // group of the function code; exponent codes fall out
        case (sf[3:2])
            `CBS_SF_GRP_LOGIC: op_kind = CBS_LOGIC;
            `CBS_SF_GRP_ARITH: op_kind = CBS_ARITH;
            `CBS_SF_GRP_NORMALIZE_OP: op_kind = CBS_NORMALIZE_OP;
            default: op_kind = CBS_NONE;
        endcase
        // fixed opcode and zero bits must match, else ignored
        legal = I_INSTR_VALID
            && (I_INSTR[`CBS_OPC_MSB:`CBS_OPC_LSB] == `CBS_OPC_TYPE16)
            && (I_INSTR[`CBS_ZERO_MSB:`CBS_ZERO_LSB] == 4'h0)
            && (op_kind != CBS_NONE) && (xop != 3'h7);
        cond_ok = cond_true(cond, I_ARITH_STATUS, I_COUNTER_EXPIRED);
        exec_go = legal && cond_ok;
        // operand sources, all sixteen bits wide
        case (xop)
            `CBS_XOP_SI: op_value = I_SHIFTER_IN;
            `CBS_XOP_UPPER: op_value = st.result[31:16];
            `CBS_XOP_LOWER: op_value = st.result[15:0];
            `CBS_XOP_ALU: op_value = I_ALU_RESULT;
            `CBS_XOP_MAC_TOP: op_value = I_MAC_RESULT_TOP;
            `CBS_XOP_MAC_MID: op_value = I_MAC_RESULT_MID;
            `CBS_XOP_MAC_LOW: op_value = I_MAC_RESULT_LOW;
            default: op_value = 16'h0000;
        endcase
        // place the operand against the chosen half
        if (!ref_lo)
        begin
            field = {op_value, 16'h0000};
        end
        else if (op_kind == CBS_ARITH)
        begin
            field = {{16{op_value[15]}}, op_value};
        end
        else
        begin
            // logical and low normalize: zeros to the left
            field = {16'h0000, op_value};
        end
        // normalize codes count the left move as negative
        if (op_kind == CBS_NORMALIZE_OP)
        begin
            amount = 8'sh00 - st.shift_code;
        end
        else
        begin
            amount = st.shift_code;
        end
        // what enters from the top on a downshift
        case (op_kind)
            CBS_ARITH: fill = field[31];
            CBS_NORMALIZE_OP:
            begin
                if (ref_lo)
                begin
                    fill = 1'b0;
                end
                else if (st.code_from_hix && st.shift_code == 8'sh01)
                begin
                    // overflowed value: true sign is the carry
                    fill = I_ARITH_STATUS[`CBS_STAT_CARRY];
                end
                else
                begin
                    fill = field[31];
                end
            end
            default: fill = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // shift network
    cbs_barrel_core #(
        .FIELD_W(32),
        .CODE_W(8)
    ) u_core (
        .i_field(field),
        .i_amount(amount),
        .i_fill(fill),
        .o_value(shifted)
    );

    // the or path lets the source build double words in two steps
    assign merged = use_or ? (st.result | shifted) : shifted;
    assign hix_store = I_EXP_HIX && I_ARITH_STATUS[`CBS_STAT_OVF];

    ////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        next_st = st;
        next_st.exec_done = 1'b0;
        // exponent store beats a port write of the code
        if (I_EXP_WE)
        begin
            next_st.shift_code = hix_store ? `CBS_HIX_CODE : I_EXP_CODE;
            next_st.code_from_hix = hix_store;
        end
        else if (I_WR && I_ADDR == `CBS_ADDR_CODE)
        begin
            next_st.shift_code = I_WR_DATA[7:0];
            next_st.code_from_hix = 1'b0;
        end
        // port writes of the result halves
        if (I_WR && I_ADDR == `CBS_ADDR_UPPER)
        begin
            next_st.result[31:16] = I_WR_DATA;
        end
        if (I_WR && I_ADDR == `CBS_ADDR_LOWER)
        begin
            next_st.result[15:0] = I_WR_DATA;
        end
        // an executed shift wins over a port write
        if (exec_go)
        begin
            next_st.result = merged;
            next_st.exec_done = 1'b1;
        end
        // read data only refresh on a read strobe
        if (I_RD)
        begin
            case (I_ADDR)
                `CBS_ADDR_CODE: next_st.rd_data = {{8{st.shift_code[7]}}, st.shift_code};
                `CBS_ADDR_UPPER: next_st.rd_data = st.result[31:16];
                `CBS_ADDR_LOWER: next_st.rd_data = st.result[15:0];
                // flags are only observed, never written here
                `CBS_ADDR_STATUS: next_st.rd_data = {7'h00, st.code_from_hix, I_ARITH_STATUS};
                default: next_st.rd_data = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign O_RD_DATA = st.rd_data;
    assign O_SHIFT_RESULT_UPPER = st.result[31:16];
    assign O_SHIFT_RESULT_LOWER = st.result[15:0];
    assign O_SHIFT_CODE = st.shift_code;
    assign O_CODE_FROM_HIX = st.code_from_hix;
    assign O_EXEC_DONE = st.exec_done;

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cbs_cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_B);

    // independent reference values for the checks
    logic [31:0] chk_left;
    logic [31:0] chk_right;
    cbs_code_type neg_code;
    assign neg_code = 8'sh00 - st.shift_code;
    assign chk_left = {op_value, 16'h0000} << st.shift_code[3:0];
    assign chk_right = {16'h0000, op_value} >> neg_code[3:0];

    AST_NO_EXEC_ON_FALSE: assert property (
        (legal && !cond_ok) |=> !O_EXEC_DONE)
        else $error("shift ran with false condition");

    AST_ALWAYS_RUNS: assert property (
        (legal && cond == `CBS_COND_ALWAYS) |=> O_EXEC_DONE)
        else $error("unconditional shift did not run");

    AST_BAD_FORMAT: assert property (
        (I_INSTR_VALID && I_INSTR[`CBS_ZERO_MSB:`CBS_ZERO_LSB] != 4'h0) |=> !O_EXEC_DONE)
        else $error("malformed instruction executed");

    AST_LOGIC_LEFT: assert property (
        (exec_go && op_kind == CBS_LOGIC && sf[1:0] == 2'h0
            && st.shift_code >= 0 && st.shift_code < 16)
        |=> {O_SHIFT_RESULT_UPPER, O_SHIFT_RESULT_LOWER} == $past(chk_left))
        else $error("logical upshift wrong");

    AST_LOGIC_RIGHT: assert property (
        (exec_go && op_kind == CBS_LOGIC && sf[1:0] == 2'h2
            && st.shift_code < 0 && st.shift_code > -16)
        |=> {O_SHIFT_RESULT_UPPER, O_SHIFT_RESULT_LOWER} == $past(chk_right))
        else $error("logical downshift wrong");

    AST_ARITH_SIGN: assert property (
        (exec_go && op_kind == CBS_ARITH && sf[1:0] == 2'h2 && st.shift_code == 0)
        |=> O_SHIFT_RESULT_UPPER == {16{$past(op_value[15])}})
        else $error("sign not copied left");

    AST_OR_KEEPS: assert property (
        (exec_go && use_or)
        |=> ({O_SHIFT_RESULT_UPPER, O_SHIFT_RESULT_LOWER} & $past(st.result)) == $past(st.result))
        else $error("or option lost result bits");

    AST_HUGE_CODE: assert property (
        (exec_go && op_kind == CBS_LOGIC && !use_or && st.shift_code >= 32)
        |=> O_SHIFT_RESULT_UPPER == 16'h0000 && O_SHIFT_RESULT_LOWER == 16'h0000)
        else $error("oversize shift left bits behind");

    AST_HIX_PLUS_ONE: assert property (
        (I_EXP_WE && hix_store) |=> O_SHIFT_CODE == 8'sh01 && O_CODE_FROM_HIX)
        else $error("overflow exponent not stored as one");

    AST_NORMALIZE_OP_CARRY: assert property (
        (exec_go && op_kind == CBS_NORMALIZE_OP && sf[1:0] == 2'h0
            && st.code_from_hix && st.shift_code == 8'sh01)
        |=> {O_SHIFT_RESULT_UPPER, O_SHIFT_RESULT_LOWER}
            == {$past(I_ARITH_STATUS[`CBS_STAT_CARRY]), $past(op_value), 15'h0000})
        else $error("normalize carry fill wrong");
endmodule

`default_nettype wire

// file: src/cbs_regs.svh
/*
 * offsets, instruction field positions, codes and reset values
 * of the conditional barrel shifter.
 * assumes: included by bare name, definitions only.
 */
`ifndef CBS_REGS_SVH
`define CBS_REGS_SVH

// register port map, word addressed
`define CBS_ADDR_W 3
`define CBS_ADDR_CODE 3'h0
`define CBS_ADDR_UPPER 3'h1
`define CBS_ADDR_LOWER 3'h2
`define CBS_ADDR_STATUS 3'h3

// instruction word fields
`define CBS_OPC_MSB 23
`define CBS_OPC_LSB 15
`define CBS_OPC_TYPE16 9'h01C
`define CBS_SF_MSB 14
`define CBS_SF_LSB 11
`define CBS_XOP_MSB 10
`define CBS_XOP_LSB 8
`define CBS_ZERO_MSB 7
`define CBS_ZERO_LSB 4
`define CBS_COND_MSB 3
`define CBS_COND_LSB 0

// function field: group in bits 3:2, low ref bit 1, or bit 0
`define CBS_SF_GRP_LOGIC 2'h0
`define CBS_SF_GRP_ARITH 2'h1
`define CBS_SF_GRP_NORMALIZE_OP 2'h2
`define CBS_SF_LO_BIT 1
`define CBS_SF_OR_BIT 0

// operand select codes
`define CBS_XOP_SI 3'h0
`define CBS_XOP_UPPER 3'h1
`define CBS_XOP_LOWER 3'h2
`define CBS_XOP_ALU 3'h3
`define CBS_XOP_MAC_TOP 3'h4
`define CBS_XOP_MAC_MID 3'h5
`define CBS_XOP_MAC_LOW 3'h6

// condition codes
`define CBS_COND_EQ 4'h0
`define CBS_COND_NE 4'h1
`define CBS_COND_GT 4'h2
`define CBS_COND_LE 4'h3
`define CBS_COND_LT 4'h4
`define CBS_COND_GE 4'h5
`define CBS_COND_AV 4'h6
`define CBS_COND_NOT_AV 4'h7
`define CBS_COND_AC 4'h8
`define CBS_COND_NOT_AC 4'h9
`define CBS_COND_NEG 4'hA
`define CBS_COND_POS 4'hB
`define CBS_COND_MV 4'hC
`define CBS_COND_NOT_MV 4'hD
`define CBS_COND_NOT_CE 4'hE
`define CBS_COND_ALWAYS 4'hF

// bit positions inside the arithmetic status word
`define CBS_STAT_ZERO 0
`define CBS_STAT_NEG 1
`define CBS_STAT_OVF 2
`define CBS_STAT_CARRY 3
`define CBS_STAT_MAC_OVF 6

// shift code forced by overflow exponent mode, reset values
`define CBS_HIX_CODE 8'h01
`define CBS_CODE_RST 8'h00
`define CBS_RESULT_RST 32'h0000_0000

`endif

// file: src/cbs_pkg.sv
/*
 * types of the conditional barrel shifter.
 * assumes: compiled before every module of the block.
 */
`default_nettype none

package cbs_pkg;
    // signed shift code, positive moves toward the msb except for normalize
    typedef logic signed [7:0] cbs_code_type;
    // one data word of the processor
    typedef logic [15:0] cbs_word_type;
    // shift kinds picked by the function field
    typedef enum logic [1:0] {CBS_LOGIC, CBS_ARITH, CBS_NORMALIZE_OP, CBS_NONE} cbs_op_type;
    // whole state of the shifter top
    typedef struct packed {
        cbs_code_type shift_code;
        logic code_from_hix;
        logic [31:0] result;
        logic exec_done;
        cbs_word_type rd_data;
    } cbs_state_type;
endpackage

`default_nettype wire

// file: src/cbs_barrel_core.sv
/*
 * combinational barrel core: moves a field by a signed amount.
 * assumes: the caller builds the field and registers the output.
 */
`default_nettype none

module cbs_barrel_core #(
    parameter int FIELD_W = 32,
    parameter int CODE_W = 8
) (
    input wire logic [FIELD_W-1:0] i_field,
    input wire logic signed [CODE_W-1:0] i_amount,
    input wire logic i_fill,
    output logic [FIELD_W-1:0] o_value
);
    localparam int MAG_W = CODE_W + 1;

    // magnitude needs one more bit so the most negative code fits
    logic [MAG_W-1:0] mag;
    logic [2*FIELD_W-1:0] ext_right;

    ////////////////////////////////////////////////////////////////
    // shift network
    always_comb
    begin
        // magnitude of the signed amount
        if (i_amount[CODE_W-1])
        begin
            mag = ~{i_amount[CODE_W-1], i_amount} + 1'b1;
        end
        else
        begin
            mag = {1'b0, i_amount};
        end
        // fill bits enter from the top on a downshift
        ext_right = {{FIELD_W{i_fill}}, i_field} >> mag;
        // whole width or more: only fill bits remain on a downshift, zeros on an upshift
        if (mag >= MAG_W'(FIELD_W))
        begin
            o_value = i_amount[CODE_W-1] ? {FIELD_W{i_fill}} : '0;
        end
        else if (i_amount[CODE_W-1])
        begin
            o_value = ext_right[FIELD_W-1:0];
        end
        else
        begin
            o_value = i_field << mag;
        end
    end
endmodule

`default_nettype wire

// file: testbench/tb_top.sv
/*
 * self-checking bench of the conditional barrel shifter top.
 * assumes: cbs_pkg and the design sources compiled first, one 50 MHz clock.
 */
`include "cbs_regs.svh"
`default_nettype none

`define CHK(nm, ex, gt) \
begin \
    checks_done++; \
    if ((gt) !== (ex)) \
    begin \
        n_fail++; \
        $display("wrong value %s expected %h seen %h", nm, ex, gt); \
    end \
end

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import cbs_pkg::*;

    ////////////////////////////////////////////////////////////
    logic sys_clk; // 20 ns period
    logic rst_b; // active low
    logic instr_valid, counter_expired, exp_we, exp_hix, wr, rd;
    logic [23:0] instr;
    cbs_word_type shifter_in, alu_result, mac_top, mac_mid, mac_low, wr_data;
    cbs_word_type rd_data, res_upper, res_lower;
    logic [7:0] arith_status;
    cbs_code_type exp_code, shift_code;
    logic [2:0] addr;
    logic code_from_hix, exec_done;
    int n_fail = 0; // mismatches
    int checks_done = 0; // comparisons

    cbs_shifter dut_u (.I_SYS_CLK(sys_clk), .I_RST_B(rst_b), .I_INSTR_VALID(instr_valid), .I_INSTR(instr),
        .I_SHIFTER_IN(shifter_in), .I_ALU_RESULT(alu_result), .I_MAC_RESULT_TOP(mac_top),
        .I_MAC_RESULT_MID(mac_mid), .I_MAC_RESULT_LOW(mac_low), .I_ARITH_STATUS(arith_status),
        .I_COUNTER_EXPIRED(counter_expired), .I_EXP_WE(exp_we), .I_EXP_HIX(exp_hix), .I_EXP_CODE(exp_code),
        .I_ADDR(addr), .I_WR_DATA(wr_data), .I_WR(wr), .I_RD(rd), .O_RD_DATA(rd_data),
        .O_SHIFT_RESULT_UPPER(res_upper), .O_SHIFT_RESULT_LOWER(res_lower), .O_SHIFT_CODE(shift_code),
        .O_CODE_FROM_HIX(code_from_hix), .O_EXEC_DONE(exec_done));

    // free running processor clock
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////
    // instruction word: fixed opcode, function, operand, zero nibble, condition
    function automatic logic [23:0] mk(input logic [3:0] sf, input logic [2:0] xop, input logic [3:0] cnd);
        return {`CBS_OPC_TYPE16, sf, xop, 4'h0, cnd};
    endfunction

    // condition truth from status bits, one entry per code
    function automatic logic cond_ok(input logic [3:0] c, input logic [7:0] s, input logic ce);
        logic lt;
        logic [15:0] t;
        lt = s[1] ^ s[2];
        t = {1'b1, !ce, !s[6], s[6], !s[1], s[1], !s[3], s[3], !s[2], s[2], !lt, lt, lt | s[0], !(lt | s[0]),
            !s[0], s[0]};
        return t[c];
    endfunction

    // reference shifter, kept apart from the design on purpose
    function automatic logic [31:0] model(input logic [3:0] sf, input cbs_word_type op, input cbs_code_type code,
        input logic overflow_exponent_mode, input logic carry);
        logic [31:0] f;
        int a;
        logic fill;
        f = (sf[3:2] == 2'h1) ? {{16{op[15]}}, op} : {16'h0000, op};
        if (!sf[1])
            f = {op, 16'h0000};
        a = (sf[3:2] == 2'h2) ? -int'(code) : int'(code);
        fill = (sf[3:2] != 2'h0) && !(sf[3:2] == 2'h2 && sf[1]) && f[31];
        // only the high normalize after a forced code takes the carry
        if (sf[3:2] == 2'h2 && !sf[1] && code == 8'sh01 && overflow_exponent_mode)
            fill = carry;
        if (a >= 32)
            return 32'h0000_0000;
        if (a >= 0)
            return f << a;
        if (a <= -32)
            return {32{fill}};
        return (f >> -a) | ({32{fill}} << (32 + a));
    endfunction

    ////////////////////////////////////////////////////////////
    // register port write, one cycle strobe
    task automatic wr_reg(input logic [2:0] a, input cbs_word_type d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    // register port read, data taken in the following cycle only
    task automatic rd_reg(input logic [2:0] a, output cbs_word_type d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rd_data;
    endtask

    // one instruction, done pulse settled when this returns
    task automatic run(input logic [23:0] w, input cbs_word_type op);
        @(posedge sys_clk);
        instr <= w;
        shifter_in <= op;
        instr_valid <= 1'b1;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    // exponent store with status word presented beside it
    task automatic store_exp(input logic overflow_exponent_mode, input cbs_code_type c, input logic [7:0] st);
        @(posedge sys_clk);
        exp_we <= 1'b1;
        exp_hix <= overflow_exponent_mode;
        exp_code <= c;
        arith_status <= st;
        @(posedge sys_clk);
        exp_we <= 1'b0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////
    // every function code against a spread of codes, odd codes merge
    task automatic t_table();
        cbs_code_type codes[7] = '{8'sh03, 8'shFB, 8'sh00, 8'sh11, 8'shEF, 8'sh28, 8'shD8};
        cbs_word_type op;
        logic [31:0] ex;
        for (int sf = 0; sf < 12; sf++)
            for (int k = 0; k < 7; k++)
            begin
                op = k[0] ? 16'h9A5C : 16'h35A1;
                wr_reg(`CBS_ADDR_CODE, {{8{codes[k][7]}}, codes[k]});
                wr_reg(`CBS_ADDR_UPPER, 16'h0F0F);
                wr_reg(`CBS_ADDR_LOWER, 16'h8001);
                run(mk(sf[3:0], `CBS_XOP_SI, `CBS_COND_ALWAYS), op);
                ex = model(sf[3:0], op, codes[k], 1'b0, 1'b0) | (sf[0] ? 32'h0F0F_8001 : 32'h0000_0000);
                `CHK("done", 1'b1, exec_done)
                `CHK("upper", ex[31:16], res_upper)
                `CHK("lower", ex[15:0], res_lower)
            end
    endtask

    // all sixteen conditions under several status words
    task automatic t_cond();
        logic [7:0] st[4] = '{8'h00, 8'h4F, 8'h06, 8'h0A};
        cbs_word_type d;
        logic ex;
        wr_reg(`CBS_ADDR_CODE, 16'h0001);
        for (int j = 0; j < 4; j++)
        begin
            @(posedge sys_clk);
            arith_status <= st[j];
            counter_expired <= j[0];
            for (int c = 0; c < 16; c++)
            begin
                wr_reg(`CBS_ADDR_LOWER, 16'h0000);
                run(mk(4'h2, `CBS_XOP_SI, c[3:0]), 16'h0001);
                ex = cond_ok(c[3:0], st[j], j[0]);
                `CHK("cond done", ex, exec_done)
                `CHK("cond lower", ex ? 16'h0002 : 16'h0000, res_lower)
            end
            rd_reg(`CBS_ADDR_STATUS, d);
            `CHK("status", {8'h00, st[j]}, d)
        end
    endtask

    // every operand source, then malformed words that must be ignored
    task automatic t_format();
        cbs_word_type srcs[7] = '{16'h7777, 16'h5555, 16'h6666, 16'h1111, 16'h2222, 16'h3333, 16'h4444};
        logic [23:0] bad[4];
        bad = '{mk(4'h2, 3'h7, 4'hF), mk(4'h2, 3'h0, 4'hF) | 24'h00_0010, mk(4'h2, 3'h0, 4'hF) ^ 24'h00_8000,
            mk(4'hC, 3'h0, 4'hF)};
        wr_reg(`CBS_ADDR_CODE, 16'h0000);
        for (int x = 0; x < 7; x++)
        begin
            wr_reg(`CBS_ADDR_UPPER, 16'h5555);
            wr_reg(`CBS_ADDR_LOWER, 16'h6666);
            run(mk(4'h2, x[2:0], `CBS_COND_ALWAYS), 16'h7777);
            `CHK("xop lower", srcs[x], res_lower)
            `CHK("xop upper", 16'h0000, res_upper)
        end
        for (int b = 0; b < 4; b++)
        begin
            run(bad[b], 16'h7777);
            `CHK("bad done", 1'b0, exec_done)
            // refused word leaves the last good result in place
            `CHK("bad lower", srcs[6], res_lower)
        end
    endtask

    // forced plus one code and carry fill of the high normalize
    task automatic t_hix();
        store_exp(1'b1, 8'shFD, 8'h0C);
        `CHK("hix code", 8'sh01, shift_code)
        `CHK("hix flag", 1'b1, code_from_hix)
        run(mk(4'h8, `CBS_XOP_SI, `CBS_COND_ALWAYS), 16'h4000);
        `CHK("carry fill", 16'hA000, res_upper)
        store_exp(1'b1, 8'shFD, 8'h08);
        `CHK("plain code", 8'shFD, shift_code)
        `CHK("plain flag", 1'b0, code_from_hix)
        wr_reg(`CBS_ADDR_CODE, 16'h0001);
        run(mk(4'h8, `CBS_XOP_SI, `CBS_COND_ALWAYS), 16'h4000);
        `CHK("sign fill", 16'h2000, res_upper)
    endtask

    // double word shifted as two back to back halves, then port reads
    task automatic t_double();
        cbs_code_type cd[2] = '{8'shFC, 8'sh05};
        logic [31:0] full;
        cbs_word_type d;
        full = 32'h8123_F0F1;
        for (int i = 0; i < 2; i++)
        begin
            wr_reg(`CBS_ADDR_CODE, {{8{cd[i][7]}}, cd[i]});
            wr_reg(`CBS_ADDR_UPPER, 16'hAAAA);
            @(posedge sys_clk);
            instr <= mk(4'h0, `CBS_XOP_SI, `CBS_COND_ALWAYS);
            shifter_in <= full[31:16];
            instr_valid <= 1'b1;
            @(posedge sys_clk);
            instr <= mk(4'h3, `CBS_XOP_SI, `CBS_COND_ALWAYS);
            shifter_in <= full[15:0];
            @(posedge sys_clk);
            instr_valid <= 1'b0;
            #1;
            `CHK("pair done", 1'b1, exec_done)
            `CHK("pair", i ? full << 5 : full >> 4, {res_upper, res_lower})
            @(posedge sys_clk);
            #1;
            `CHK("done drop", 1'b0, exec_done)
        end
        rd_reg(`CBS_ADDR_UPPER, d);
        `CHK("read upper", full[26:11], d)
        wr_reg(3'h6, 16'h1234);
        rd_reg(3'h5, d);
        `CHK("unmapped", 16'h0000, d)
        `CHK("kept upper", full[26:11], res_upper)
    endtask

    ////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // hang guard, far beyond the roughly one thousand cycles the tests need
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        results();
    end

    // main sequence
    initial
    begin
        {rst_b, instr_valid, counter_expired, exp_we, exp_hix, wr, rd} = 7'h00;
        {instr, addr, arith_status, exp_code} = '0;
        {shifter_in, alu_result, mac_top, mac_mid, mac_low, wr_data} = '0;
        alu_result = 16'h1111;
        mac_top = 16'h2222;
        mac_mid = 16'h3333;
        mac_low = 16'h4444;
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1;
        `CHK("reset result", 32'h0000_0000, {res_upper, res_lower})
        `CHK("reset code", 8'sh00, shift_code)
        `CHK("reset done", 1'b0, exec_done)
        t_table();
        t_cond();
        t_format();
        t_hix();
        t_double();
        results();
    end
endmodule

`default_nettype wire
